//--- osc_step_control.sv
// Oscillator step control: loop filter, combined divider/stage accumulator,
// ring length and fine-adjust dither, monitor gating and control registers.
// Assumes a frequency comparator on ref_clk and an analog ring and divider.
//
// Summary of operation
// R01: Effective divider exponent caps at 9 (divide by 512); codes 10-15 act as 9.
// R02: Exponent 0 passes ring undivided; each step doubles or halves the period.
// R03: While the generator runs, the exponent moves only by carry or borrow out of the stage-control value.
// R04: Upper three stage bits select ring length 17 to 31 delays, steps of two.
// R05: Lower five stage bits k lengthen ring by two delays k of 32 cycles.
// R06: At upper code 7 the alternate point is 17 delays with divide-by-two.
// R07: In the coarse phase, above 15 percent error each correction moves the stage value by 32.
// R08: The smallest correction is one least-significant stage step.
// R09: The loop regulates the clock to N times the 307.2 kHz reference.
// R10: Software turns the monitor off before changing N.
// R11: After an N change a monitor enable waits for the stable flag.
// R12: N writes are accepted at any time with no interlock.
// R13: Software checks the fault flag, disables monitor, writes N, re-enables.
// R14: Reset, N change, trim change or generator restart begin a new settling.
// R15: One correction every four low-rate reference periods.
// R16: Coarse corrections: eight of them double or halve the period.
// R17: Medium corrections between 15 and 5 percent, at most eight; then stable.
// R18: Within 5 percent only single steps, at most 24 before tracking.
// R19: While stopped, software writes exponent and stage value; restart uses them.
// R20: Exponent and stage value form one accumulator that saturates at both ends.
//
// The address-and-strobe port and the placing of the registers were left to the implementer.
`timescale 1ns/10ps
`include "osc_defines.svh"

module osc_step_control
    import osc_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic [2:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [15:0] reg_rdata,
    input wire logic low_rate_reference,
    input wire logic err_above15,
    input wire logic err_above5,
    input wire logic period_short,
    input wire logic stop_mode,
    output logic [3:0] divider_exponent,
    output logic [2:0] ring_len_code,
    output logic ring_half,
    output logic [6:0] mult_factor,
    output logic [7:0] trim_value,
    output logic internal_clock_stable_flag,
    output logic monitor_enable,
    output logic generator_run
);

    // ------------------------------------------------------------------
    // Accumulator arithmetic
    // ------------------------------------------------------------------
    function automatic osc_acc_t acc_step(input osc_acc_t acc, input osc_acc_t step, input logic up);
        logic [12:0] sum;
        osc_acc_t base;
        base = (acc[11:8] > `OSC_DIV_MAX) ? {`OSC_DIV_MAX, acc[7:0]} : acc; // [R01]
        sum = 13'h0000;
        if (up) begin
            sum = {1'b0, base} + {1'b0, step}; // [R03]
            acc_step = (sum > {1'b0, `OSC_ACC_MAX}) ? `OSC_ACC_MAX : sum[11:0]; // [R20]
        end else begin
            acc_step = (base < step) ? 12'h000 : base - step; // [R03] [R20]
        end
    endfunction

    // ------------------------------------------------------------------
    // Registers and next values
    // ------------------------------------------------------------------
    logic gen_on_r;
    logic mon_req_r;
    logic n_lock_r;
    logic stable_r;
    logic run_prev_r;
    osc_acc_t acc_r;
    osc_acc_t acc_nxt;
    osc_phase_e phase_r;
    osc_phase_e phase_nxt;
    logic [4:0] corr_cnt_r;
    logic [4:0] corr_cnt_nxt;
    logic stable_nxt;
    logic [4:0] dither_r;
    logic [5:0] dither_sum;
    logic stretch;
    logic gen_run_now;
    logic restart;
    logic corr_tick;
    logic wr_ctrl;
    logic wr_mult;
    logic wr_trim;
    logic wr_div;
    logic wr_stg;
    logic [15:0] rd_mux;
    logic [15:0] status_word;
    osc_acc_t step_sel;

    // ------------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------------
    assign wr_ctrl = reg_wr && (reg_addr == `OSC_ADDR_CTRL);
    assign wr_mult = reg_wr && (reg_addr == `OSC_ADDR_MULT); // [R12]
    assign wr_trim = reg_wr && (reg_addr == `OSC_ADDR_TRIM);
    assign wr_div = reg_wr && (reg_addr == `OSC_ADDR_DIV) && !gen_run_now; // [R19]
    assign wr_stg = reg_wr && (reg_addr == `OSC_ADDR_STG) && !gen_run_now; // [R19]

    assign status_word = {8'h00, phase_r, n_lock_r, generator_run, monitor_enable, stable_r};

    always_comb begin
        if (reg_addr == `OSC_ADDR_CTRL) begin
            rd_mux = {14'h0000, mon_req_r, gen_on_r};
        end else if (reg_addr == `OSC_ADDR_MULT) begin
            rd_mux = {9'h000, mult_factor};
        end else if (reg_addr == `OSC_ADDR_TRIM) begin
            rd_mux = {8'h00, trim_value};
        end else if (reg_addr == `OSC_ADDR_DIV) begin
            rd_mux = {12'h000, acc_r[11:8]};
        end else if (reg_addr == `OSC_ADDR_STG) begin
            rd_mux = {8'h00, acc_r[7:0]};
        end else if (reg_addr == `OSC_ADDR_STAT) begin
            rd_mux = status_word;
        end else begin
            rd_mux = 16'h0000;
        end
    end

    // ------------------------------------------------------------------
    // Settling restart and correction pacing
    // ------------------------------------------------------------------
    assign gen_run_now = gen_on_r & ~stop_mode;
    assign restart = wr_mult | wr_trim | (gen_run_now & ~run_prev_r); // [R14]

    osc_ref_pacer u_pacer (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .low_rate_reference(low_rate_reference), // [R09]
        .restart(restart),
        .corr_tick(corr_tick)
    );

    // ------------------------------------------------------------------
    // Loop filter phases
    // ------------------------------------------------------------------
    always_comb begin
        phase_nxt = phase_r;
        corr_cnt_nxt = corr_cnt_r;
        stable_nxt = stable_r;
        step_sel = `OSC_STEP_FINE; // [R08]
        case (phase_r)
            OSC_PH_COARSE: begin
                if (err_above15) begin
                    step_sel = `OSC_STEP_COARSE; // [R07] [R16]
                end else if (err_above5) begin
                    step_sel = `OSC_STEP_MEDIUM;
                    phase_nxt = OSC_PH_MEDIUM;
                    corr_cnt_nxt = 5'h01;
                end else begin
                    phase_nxt = OSC_PH_FINE;
                    corr_cnt_nxt = 5'h01;
                    stable_nxt = 1'b1; // [R17]
                end
            end
            OSC_PH_MEDIUM: begin
                if (err_above5 && corr_cnt_r < `OSC_MEDIUM_MAX) begin
                    step_sel = `OSC_STEP_MEDIUM; // [R17]
                    corr_cnt_nxt = corr_cnt_r + 5'h01;
                end else begin
                    phase_nxt = OSC_PH_FINE;
                    corr_cnt_nxt = 5'h01;
                    stable_nxt = 1'b1; // [R17]
                end
            end
            OSC_PH_FINE: begin
                corr_cnt_nxt = corr_cnt_r + 5'h01;
                if (corr_cnt_r >= `OSC_FINE_MAX - 5'h01) begin
                    phase_nxt = OSC_PH_TRACK; // [R18]
                end
            end
            OSC_PH_TRACK: begin
                corr_cnt_nxt = corr_cnt_r;
            end
            default: begin
                phase_nxt = OSC_PH_COARSE;
            end
        endcase
    end

    always_comb begin
        if (wr_div) begin
            acc_nxt = {reg_wdata[3:0], acc_r[7:0]}; // [R19]
        end else if (wr_stg) begin
            acc_nxt = {acc_r[11:8], reg_wdata[7:0]}; // [R19]
        end else if (gen_run_now && corr_tick && !restart) begin
            acc_nxt = acc_step(acc_r, step_sel, period_short); // [R15]
        end else begin
            acc_nxt = acc_r;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            phase_r <= OSC_PH_COARSE; // [R14]
            corr_cnt_r <= 5'h00;
            stable_r <= 1'b0;
        end else if (restart || !gen_run_now) begin
            phase_r <= OSC_PH_COARSE; // [R14]
            corr_cnt_r <= 5'h00;
            stable_r <= 1'b0;
        end else if (corr_tick) begin
            phase_r <= phase_nxt;
            corr_cnt_r <= corr_cnt_nxt;
            stable_r <= stable_nxt;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            acc_r <= {`OSC_RST_DIV, `OSC_RST_STG};
            run_prev_r <= 1'b0;
        end else begin
            acc_r <= acc_nxt;
            run_prev_r <= gen_run_now;
        end
    end

    // ------------------------------------------------------------------
    // Fine-adjust dither: k of every 32 cycles run two delays longer
    // ------------------------------------------------------------------
    assign dither_sum = {1'b0, dither_r} + {1'b0, acc_r[4:0]};
    assign stretch = dither_sum[5]; // [R05]

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            dither_r <= 5'h00;
        end else begin
            dither_r <= dither_sum[4:0];
        end
    end

    // ------------------------------------------------------------------
    // Ring and divider controls
    // ------------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            divider_exponent <= `OSC_RST_DIV;
            ring_len_code <= 3'h0;
            ring_half <= 1'b0;
        end else begin
            divider_exponent <= (acc_r[11:8] > `OSC_DIV_MAX) ? `OSC_DIV_MAX : acc_r[11:8]; // [R01] [R02]
            if (stretch && acc_r[7:5] == `OSC_TOP_STAGE) begin
                ring_len_code <= 3'h0; // [R06]
                ring_half <= 1'b1; // [R06]
            end else begin
                ring_len_code <= acc_r[7:5] + {2'b00, stretch}; // [R04] [R05]
                ring_half <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------------
    // Control registers and monitor gating
    // ------------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            gen_on_r <= `OSC_RST_GEN_ON;
            mon_req_r <= `OSC_RST_MON_REQ;
            mult_factor <= `OSC_RST_MULT;
            trim_value <= `OSC_RST_TRIM;
            n_lock_r <= 1'b0;
        end else begin
            if (wr_ctrl) begin
                gen_on_r <= reg_wdata[`OSC_CTRL_GEN_ON];
                mon_req_r <= reg_wdata[`OSC_CTRL_MON_REQ];
            end
            if (wr_mult) begin
                mult_factor <= reg_wdata[6:0]; // [R12]
            end
            if (wr_trim) begin
                trim_value <= reg_wdata[7:0];
            end
            if (wr_mult) begin
                n_lock_r <= 1'b1; // [R11]
            end else if (stable_r) begin
                n_lock_r <= 1'b0; // [R11]
            end
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            monitor_enable <= 1'b0;
            internal_clock_stable_flag <= 1'b0;
            generator_run <= 1'b0;
            reg_rdata <= 16'h0000;
        end else begin
            monitor_enable <= mon_req_r & ~n_lock_r & ~wr_mult; // [R11] [R10]
            internal_clock_stable_flag <= stable_r;
            generator_run <= gen_run_now;
            reg_rdata <= reg_rd ? rd_mux : 16'h0000;
        end
    end

endmodule // osc_step_control

//--- osc_defines.svh
// Constants for the oscillator step control: register offsets, field
// positions, reset values, step sizes and pacing counts.
// Assumes inclusion by every design file that needs it.
`ifndef OSC_DEFINES_SVH
`define OSC_DEFINES_SVH

// ----------------------------------------------------------------------
// Register offsets (word index on the plain register port)
// ----------------------------------------------------------------------
`define OSC_ADDR_CTRL 3'h0
`define OSC_ADDR_MULT 3'h1
`define OSC_ADDR_TRIM 3'h2
`define OSC_ADDR_DIV 3'h3
`define OSC_ADDR_STG 3'h4
`define OSC_ADDR_STAT 3'h5

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define OSC_CTRL_GEN_ON 0
`define OSC_CTRL_MON_REQ 1
`define OSC_STAT_STABLE 0
`define OSC_STAT_MON_EN 1
`define OSC_STAT_GEN_RUN 2
`define OSC_STAT_LOCK 3
`define OSC_STAT_PHASE_LSB 4

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define OSC_RST_GEN_ON 1'h1
`define OSC_RST_MON_REQ 1'h0
`define OSC_RST_MULT 7'h15
`define OSC_RST_TRIM 8'h80
`define OSC_RST_DIV 4'h0
`define OSC_RST_STG 8'h80

// ----------------------------------------------------------------------
// Loop steps, limits and pacing
// ----------------------------------------------------------------------
`define OSC_DIV_MAX 4'h9
`define OSC_ACC_MAX 12'h9FF
`define OSC_STEP_COARSE 12'h020
`define OSC_STEP_MEDIUM 12'h008
`define OSC_STEP_FINE 12'h001
`define OSC_MEDIUM_MAX 5'h08
`define OSC_FINE_MAX 5'h18
`define OSC_TOP_STAGE 3'h7
`define OSC_CORR_REF_PERIODS 3'h4
`define OSC_LRR_FREQ_HZ 307200
`define OSC_REF_CLK_HZ 25000000
`define OSC_LRR_PERIOD_CYC (`OSC_REF_CLK_HZ / `OSC_LRR_FREQ_HZ)

`endif

//--- osc_pkg.sv
// Types shared by the oscillator step control files.
// Assumes nothing beyond a SystemVerilog compiler.
package osc_pkg;

    // ------------------------------------------------------------------
    // Settling phases of the loop filter
    // ------------------------------------------------------------------
    typedef enum logic [3:0] {
        OSC_PH_COARSE = 4'b0001,
        OSC_PH_MEDIUM = 4'b0010,
        OSC_PH_FINE = 4'b0100,
        OSC_PH_TRACK = 4'b1000
    } osc_phase_e;

    typedef logic [11:0] osc_acc_t;

endpackage

//--- osc_ref_pacer.sv
// Low-rate reference synchroniser and correction pacer.
// Assumes the reference arrives asynchronously on a pin.
`timescale 1ns/10ps
`include "osc_defines.svh"

module osc_ref_pacer (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic low_rate_reference,
    input wire logic restart,
    output logic corr_tick
);

    // ------------------------------------------------------------------
    // Three-stage synchroniser with agreement filter
    // ------------------------------------------------------------------
    logic sync1_r;
    logic sync2_r;
    logic sync3_r;
    logic level_r;
    logic [2:0] edge_cnt_r;
    logic [2:0] edge_cnt_nxt;
    logic agree;
    logic rise;
    logic last_edge;

    assign agree = (sync2_r == sync3_r);
    assign rise = agree & sync3_r & ~level_r;
    assign last_edge = (edge_cnt_r == `OSC_CORR_REF_PERIODS - 3'h1);
    assign edge_cnt_nxt = restart ? 3'h0 : (rise ? (last_edge ? 3'h0 : edge_cnt_r + 3'h1) : edge_cnt_r);

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            sync1_r <= 1'b0;
            sync2_r <= 1'b0;
            sync3_r <= 1'b0;
            level_r <= 1'b0;
        end else begin
            sync1_r <= low_rate_reference;
            sync2_r <= sync1_r;
            sync3_r <= sync2_r;
            if (agree) begin
                level_r <= sync3_r;
            end
        end
    end

    // ------------------------------------------------------------------
    // One correction per four reference periods
    // ------------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            edge_cnt_r <= 3'h0;
            corr_tick <= 1'b0;
        end else begin
            edge_cnt_r <= edge_cnt_nxt;
            corr_tick <= ~restart & rise & last_edge; // [R15]
        end
    end

endmodule // osc_ref_pacer

//--- osc_step_control_asserts.sv
// Concurrent checks on the ports of the oscillator step control.
// Assumes one clock domain and a bind onto osc_step_control.
`timescale 1ns/10ps

module osc_step_control_chk (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic [2:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic stop_mode,
    input wire logic [3:0] divider_exponent,
    input wire logic [2:0] ring_len_code,
    input wire logic ring_half,
    input wire logic [6:0] mult_factor,
    input wire logic internal_clock_stable_flag,
    input wire logic monitor_enable,
    input wire logic generator_run
);
    logic lock_seen_r;

    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    // ------------------------------------------------------------------
    // Mirror of the multiply-change lock
    // ------------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            lock_seen_r <= 1'b0;
        end else if (reg_wr && reg_addr == 3'h1) begin
            lock_seen_r <= 1'b1;
        end else if ($rose(internal_clock_stable_flag)) begin
            lock_seen_r <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------------
    property p_div_cap;
        divider_exponent <= 4'h9;
    endproperty
    a_div_cap: assert property (p_div_cap) else $error("divider exponent above nine");

    property p_half_top;
        ring_half |-> ring_len_code == 3'h0;
    endproperty
    a_half_top: assert property (p_half_top) else $error("halved point outside top code");

    property p_div_step;
        generator_run && $past(generator_run) && $past(generator_run, 2) && $changed(divider_exponent)
            |-> (divider_exponent == $past(divider_exponent) + 4'h1)
                || (divider_exponent + 4'h1 == $past(divider_exponent));
    endproperty
    a_div_step: assert property (p_div_step) else $error("divider exponent jumped");

    property p_mult_take;
        reg_wr && reg_addr == 3'h1 |=> mult_factor == $past(reg_wdata[6:0]);
    endproperty
    a_mult_take: assert property (p_mult_take) else $error("multiply factor not taken");

    property p_mult_mon;
        reg_wr && reg_addr == 3'h1 |=> !monitor_enable;
    endproperty
    a_mult_mon: assert property (p_mult_mon) else $error("monitor left on after N change");

    property p_mult_settle;
        reg_wr && reg_addr == 3'h1 |-> ##2 !internal_clock_stable_flag;
    endproperty
    a_mult_settle: assert property (p_mult_settle) else $error("no settling after N change");

    property p_mon_wait;
        lock_seen_r && !internal_clock_stable_flag && !$past(internal_clock_stable_flag) |-> !monitor_enable;
    endproperty
    a_mon_wait: assert property (p_mon_wait) else $error("monitor enabled before stable");

    property p_trim_settle;
        reg_wr && reg_addr == 3'h2 |-> ##[1:2] !internal_clock_stable_flag;
    endproperty
    a_trim_settle: assert property (p_trim_settle) else $error("no settling after trim change");

    property p_stop_halt;
        stop_mode |=> !generator_run;
    endproperty
    a_stop_halt: assert property (p_stop_halt) else $error("generator runs in stop");

endmodule // osc_step_control_chk

bind osc_step_control osc_step_control_chk chk_u (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_wr(reg_wr),
    .stop_mode(stop_mode),
    .divider_exponent(divider_exponent),
    .ring_len_code(ring_len_code),
    .ring_half(ring_half),
    .mult_factor(mult_factor),
    .internal_clock_stable_flag(internal_clock_stable_flag),
    .monitor_enable(monitor_enable),
    .generator_run(generator_run)
);

//--- osc_step_control_tb_top.sv
// Self-checking bench for the oscillator step control.
// Assumes the design files and the checker are compiled first.
`timescale 1ns/10ps

module osc_step_control_tb_top;
    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    logic [2:0] reg_addr = 3'h0;
    logic [15:0] reg_wdata = 16'h0000;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic low_rate_reference = 1'b0;
    logic err_above15 = 1'b0;
    logic err_above5 = 1'b0;
    logic period_short = 1'b0;
    logic stop_mode = 1'b0;
    logic [15:0] reg_rdata;
    logic [3:0] divider_exponent;
    logic [2:0] ring_len_code;
    logic ring_half;
    logic [6:0] mult_factor;
    logic [7:0] trim_value;
    logic internal_clock_stable_flag;
    logic monitor_enable;
    logic generator_run;
    int mismatches = 0;
    int checks_done = 0;
    int lrr_cnt = 0;
    int n_long;
    int n_nom;
    integer seed = 57914;
    logic [31:0] rnd;
    logic lrr_on = 1'b0;
    logic watch = 1'b0;
    logic rd_seen = 1'b0;
    logic [6:0] loop_prev = 7'h00;
    logic [15:0] rd_q[$];
    logic [6:0] loop_q[$];
    logic [15:0] rst_tab [8] = '{16'h0001, 16'h0015, 16'h0080, 16'h0000, 16'h0080, 16'h0014, 16'h0000, 16'h0000};
    logic [7:0] stg_tab [4] = '{8'h60, 8'h65, 8'h7F, 8'hE3};

    osc_step_control dut_u (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .reg_addr(reg_addr),
        .reg_wdata(reg_wdata),
        .reg_wr(reg_wr),
        .reg_rd(reg_rd),
        .reg_rdata(reg_rdata),
        .low_rate_reference(low_rate_reference),
        .err_above15(err_above15),
        .err_above5(err_above5),
        .period_short(period_short),
        .stop_mode(stop_mode),
        .divider_exponent(divider_exponent),
        .ring_len_code(ring_len_code),
        .ring_half(ring_half),
        .mult_factor(mult_factor),
        .trim_value(trim_value),
        .internal_clock_stable_flag(internal_clock_stable_flag),
        .monitor_enable(monitor_enable),
        .generator_run(generator_run)
    );

    initial begin
        forever #20 ref_clk = ~ref_clk;
    end

    // ------------------------------------------------------------------
    // Bus tasks and comparison
    // ------------------------------------------------------------------
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            mismatches++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic cyc(input int n);
        reg_wr <= 1'b0;
        reg_rd <= 1'b0;
        repeat (n) @(posedge ref_clk);
    endtask

    task automatic wr(input logic [2:0] a, input logic [15:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_rd <= 1'b0;
        reg_wr <= 1'b1;
        @(posedge ref_clk);
    endtask

    task automatic rd(input logic [2:0] a, input logic [15:0] e);
        reg_addr <= a;
        rd_q.push_back(e);
        reg_wr <= 1'b0;
        reg_rd <= 1'b1;
        @(posedge ref_clk);
    endtask

    task automatic summarize;
        $display("checks_done=%0d mismatches=%0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask

    // ------------------------------------------------------------------
    // Reference pin, read watcher and step watcher
    // ------------------------------------------------------------------
    always @(posedge ref_clk) begin
        if (lrr_on) begin
            lrr_cnt <= (lrr_cnt == 39) ? 0 : lrr_cnt + 1;
            if (lrr_cnt == 39) low_rate_reference <= ~low_rate_reference;
        end
    end

    always @(posedge ref_clk) begin
        if (rd_seen) chk(reg_rdata, rd_q.pop_front());
        rd_seen <= reg_rd;
    end

    always @(posedge ref_clk) begin
        loop_prev <= {divider_exponent, ring_len_code};
        if (watch && {divider_exponent, ring_len_code} !== loop_prev)
            chk({9'h000, divider_exponent, ring_len_code}, (loop_q.size() > 0) ? {9'h000, loop_q.pop_front()} : 16'hFFFF);
    end

    initial begin
        repeat (20000) @(posedge ref_clk);
        mismatches++;
        summarize;
    end

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        cyc(2);
        rst_n <= 1'b1;
        cyc(2);
        chk({12'h000, divider_exponent}, 16'h0000);
        chk({13'h0000, ring_len_code}, 16'h0004);
        for (int i = 0; i < 8; i++) rd(i[2:0], rst_tab[i]);
        wr(3'h4, 16'h0033);
        wr(3'h5, 16'hFFFF);
        rd(3'h4, 16'h0080);
        rd(3'h5, 16'h0014);
        for (int i = 0; i < 3; i++) begin
            rnd = $random(seed);
            wr(3'h1, rnd[15:0]);
            rd(3'h1, {9'h000, rnd[6:0]});
        end
        // Dither counts over one 32-cycle window
        foreach (stg_tab[i]) begin
            wr(3'h0, 16'h0000);
            wr(3'h4, {8'h00, stg_tab[i]});
            wr(3'h0, 16'h0001);
            cyc(4);
            n_long = 0;
            n_nom = 0;
            repeat (32) begin
                cyc(1);
                if (stg_tab[i][7:5] == 3'h7) begin
                    n_long += (ring_half === 1'b1 && ring_len_code === 3'h0);
                    n_nom += (ring_half === 1'b0 && ring_len_code === 3'h7);
                end else begin
                    n_long += (ring_half === 1'b0 && ring_len_code === stg_tab[i][7:5] + 3'h1);
                    n_nom += (ring_half === 1'b0 && ring_len_code === stg_tab[i][7:5]);
                end
            end
            chk(n_long[15:0], {11'h000, stg_tab[i][4:0]});
            chk(n_nom[15:0], 16'h0020 - {11'h000, stg_tab[i][4:0]});
        end
        // Raw exponent above nine acts as nine
        wr(3'h0, 16'h0000);
        wr(3'h3, 16'h000C);
        wr(3'h4, 16'h0000);
        wr(3'h0, 16'h0001);
        rd(3'h3, 16'h000C);
        cyc(4);
        chk({12'h000, divider_exponent}, 16'h0009);
        // Saturation at both ends of the accumulator
        wr(3'h0, 16'h0000);
        wr(3'h3, 16'h0009);
        wr(3'h4, 16'h00E0);
        err_above15 <= 1'b1;
        period_short <= 1'b1;
        lrr_on <= 1'b1;
        wr(3'h0, 16'h0001);
        cyc(1500);
        rd(3'h4, 16'h00FF);
        rd(3'h3, 16'h0009);
        wr(3'h0, 16'h0000);
        wr(3'h3, 16'h0000);
        wr(3'h4, 16'h0010);
        period_short <= 1'b0;
        wr(3'h0, 16'h0001);
        cyc(1500);
        rd(3'h4, 16'h0000);
        rd(3'h3, 16'h0000);
        // Eight coarse steps carry into the exponent
        wr(3'h0, 16'h0000);
        wr(3'h4, 16'h0080);
        period_short <= 1'b1;
        wr(3'h0, 16'h0001);
        cyc(3);
        for (int i = 0; i < 8; i++) loop_q.push_back(7'h05 + i[6:0]);
        watch <= 1'b1;
        cyc(2700);
        watch <= 1'b0;
        chk(16'(loop_q.size()), 16'h0000);
        chk({15'h0000, internal_clock_stable_flag}, 16'h0000);
        // Fine entry, stable flag and monitor gating
        err_above15 <= 1'b0;
        err_above5 <= 1'b0;
        wr(3'h0, 16'h0001);
        wr(3'h1, 16'h0015);
        wr(3'h0, 16'h0003);
        cyc(2);
        chk({15'h0000, monitor_enable}, 16'h0000);
        for (int i = 0; i < 1200 && internal_clock_stable_flag !== 1'b1; i++) cyc(1);
        chk({15'h0000, internal_clock_stable_flag}, 16'h0001);
        cyc(3);
        chk({15'h0000, monitor_enable}, 16'h0001);
        rd(3'h5, 16'h0047);
        cyc(7400);
        rd(3'h5, 16'h0087);
        wr(3'h2, 16'h0040);
        cyc(2);
        chk({15'h0000, internal_clock_stable_flag}, 16'h0000);
        rd(3'h2, 16'h0040);
        stop_mode <= 1'b1;
        cyc(3);
        chk({15'h0000, generator_run}, 16'h0000);
        stop_mode <= 1'b0;
        cyc(3);
        chk({15'h0000, generator_run}, 16'h0001);
        summarize;
    end

endmodule // osc_step_control_tb_top
